// file: rtl/adc_output_word_formatter.sv
// output word formatter: straps, coding, test modes, delay trim and avalon registers
`timescale 1ns/1ps
`include "adc_fmt_params.svh"

module adc_output_word_formatter #(
  parameter int WIDTH = 10,
  parameter int DECIMATION = 32
) (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // quantizer result, same clock domain
  input wire logic [9:0] QUANT_DATA_I,
  input wire logic QUANT_OVER_I,
  input wire logic QUANT_UNDER_I,
  // static strap pins, asynchronous
  input wire logic CODE_FORMAT_SELECT_I,
  input wire logic TEST_PATTERN_ENABLE_N_I,
  input wire logic DECIMATE_ENABLE_N_I,
  input wire logic DELAY_TRIM_ENABLE_N_I,
  // sample word stream to the receiver
  output logic [9:0] DATA_O,
  output logic OVERRANGE_FLAG_O,
  output logic DATA_VALID_O,
  // aperture delay setting in picoseconds
  output logic [15:0] APERTURE_DELAY_O,
  // avalon-mm slave
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // level interrupt
  output logic IRQ_O
);

  // the coder and the checkerboard words are built for ten bits only
  if (WIDTH != 10) begin
    $error("word width must be 10");
  end

  // the free frame counter must wrap exactly once per frame, so only powers of two
  localparam bit DEC_OK = DECIMATION >= 2 && DECIMATION <= 256 &&
                          (DECIMATION & (DECIMATION - 1)) == 0;
  if (!DEC_OK) begin
    $error("decimation must be a power of two from 2 to 256");
  end

  localparam int DCW = $clog2(DECIMATION);

  // ---------------- strap synchronisers ----------------

  // strap pins gathered: gray, pattern, decimate, trim (all active low)
  wire [3:0] strap_pins;
  // first stage, read only by the second stage
  logic [3:0] strap_meta_q;
  // second stage, the usable strap levels
  logic [3:0] strap_sync_q;
  // previous usable levels, for change detection
  logic [3:0] strap_prev_q;

  assign strap_pins = {DELAY_TRIM_ENABLE_N_I, DECIMATE_ENABLE_N_I,
                       TEST_PATTERN_ENABLE_N_I, CODE_FORMAT_SELECT_I};

  // straps are static by intent, so the two flops only cost two cycles at start-up
  // two flops before any logic looks at a strap
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      strap_meta_q <= `STRAP_RESET;
      strap_sync_q <= `STRAP_RESET;
      strap_prev_q <= `STRAP_RESET;
    end else begin
      strap_meta_q <= strap_pins;
      strap_sync_q <= strap_meta_q;
      strap_prev_q <= strap_sync_q;
    end
  end

  // decoded modes; a strap tied to the negative supply reads as a low level
  wire gray_on;
  wire pattern_on;
  wire decimate_on;
  wire trim_on;
  // any strap moved, samples around it are suspect
  wire strap_changed;

  assign gray_on = ~strap_sync_q[0];
  assign pattern_on = ~strap_sync_q[1];
  assign decimate_on = ~strap_sync_q[2];
  assign trim_on = ~strap_sync_q[3];
  assign strap_changed = strap_sync_q != strap_prev_q;

  // ---------------- word coding ----------------

  // carrier to the coder
  coder_link_if link ();

  // checkerboard phase, flips every cycle so every bit toggles
  logic phase_q;

  assign link.raw_word = QUANT_DATA_I;
  assign link.over = QUANT_OVER_I;
  assign link.under = QUANT_UNDER_I;
  assign link.coding = gray_on ? adc_fmt_pkg::CODING_GRAY : adc_fmt_pkg::CODING_BINARY;
  assign link.pattern_on = pattern_on;
  assign link.pattern_phase = phase_q;

  // coding, saturation and pattern selection
  word_coder coder_u (
    .link(link.coder)
  );

  // phase restarts at reset, so the first checkerboard word after reset is the even one
  // toggle phase each cycle
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  // ---------------- decimation ----------------

  // position within the decimation frame
  logic [DCW-1:0] dec_count_q;
  // this cycle's sample is passed on
  wire take_sample;

  // with pattern and decimation both on the frame length is even, so every
  // picked word is the same checkerboard word; use one test mode at a time
  // counter runs freely so the chosen phase is stable while the strap holds
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      dec_count_q <= '0;
    end else begin
      dec_count_q <= dec_count_q + 1'b1;
    end
  end

  assign take_sample = ~decimate_on | (dec_count_q == '0);

  // ---------------- output registers ----------------

  // held sample word
  logic [9:0] data_q;
  // held overrange flag
  logic flag_q;
  // one cycle marker of a fresh word
  logic valid_q;

  // trade-off: the output stage adds a cycle of latency but gives clean, aligned bits
  // words are held between picks so a slow receiver sees a stable bus
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      data_q <= 10'h000;
      flag_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= take_sample;
      if (take_sample) begin
        data_q <= link.coded_word;
        flag_q <= link.coded_flag;
      end
    end
  end

  assign DATA_O = data_q;
  assign OVERRANGE_FLAG_O = flag_q;
  assign DATA_VALID_O = valid_q;

  // ---------------- register bus ----------------

  // trim offset in picoseconds, two's complement
  logic [7:0] trim_q;
  // interrupt enables
  logic [`EVT_WIDTH-1:0] enable_q;
  // sticky events
  logic [`EVT_WIDTH-1:0] status_q;
  // saturating count of flagged output words
  logic [15:0] ovr_count_q;
  // answer phase of a request
  logic ack_q;
  // registered read data
  logic [31:0] rdata_q;

  // a request that has not been answered yet
  wire req_new;
  // the request is taken at this edge
  wire req_done;
  // address decodes
  wire hit_status;
  wire hit_clear;
  wire hit_enable;
  wire hit_mode;
  wire hit_trim;
  wire hit_count;
  // writes that take effect now
  wire wr_clear;
  wire wr_enable;
  wire wr_trim;
  // read mux result
  wire [31:0] rdata_mux;
  // events of this cycle
  wire [`EVT_WIDTH-1:0] evt_now;
  // bits that software clears now
  wire [`EVT_WIDTH-1:0] clear_mask;

  // reads and writes both complete at the edge where waitrequest is low;
  // the slave never stretches further, so back to back requests cost two cycles each
  // one wait cycle: the first cycle registers read data, the second answers
  assign req_new = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign req_done = (AVS_READ_I | AVS_WRITE_I) & ack_q;
  assign AVS_WAITREQUEST_O = req_new;

  assign hit_status = AVS_ADDRESS_I == `REG_STATUS_OFS;
  assign hit_clear = AVS_ADDRESS_I == `REG_CLEAR_OFS;
  assign hit_enable = AVS_ADDRESS_I == `REG_ENABLE_OFS;
  assign hit_mode = AVS_ADDRESS_I == `REG_MODE_OFS;
  assign hit_trim = AVS_ADDRESS_I == `REG_TRIM_OFS;
  assign hit_count = AVS_ADDRESS_I == `REG_OVR_COUNT_OFS;

  // only the low byte lane carries the narrow fields
  assign wr_clear = req_done & AVS_WRITE_I & hit_clear & AVS_BYTEENABLE_I[0];
  assign wr_enable = req_done & AVS_WRITE_I & hit_enable & AVS_BYTEENABLE_I[0];
  assign wr_trim = req_done & AVS_WRITE_I & hit_trim & AVS_BYTEENABLE_I[0];

  // clear register is write-only and reads as zero
  assign rdata_mux = hit_status ? {30'h0, status_q} :
                     hit_enable ? {30'h0, enable_q} :
                     hit_mode ? {28'h0, trim_on, decimate_on, pattern_on, gray_on} :
                     hit_trim ? {24'h0, trim_q} :
                     hit_count ? {16'h0, ovr_count_q} :
                     `READ_DEFAULT;

  // bus handshake and read capture
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_new;
      if (req_new) begin
        rdata_q <= rdata_mux;
      end
    end
  end

  assign AVS_READDATA_O = rdata_q;

  // software held settings
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      enable_q <= `ENABLE_RESET;
      trim_q <= `TRIM_RESET;
    end else begin
      if (wr_enable) begin
        enable_q <= AVS_WRITEDATA_I[`EVT_WIDTH-1:0];
      end
      if (wr_trim) begin
        trim_q <= AVS_WRITEDATA_I[7:0];
      end
    end
  end

  // ---------------- events and interrupt ----------------

  // a word leaving with its flag high is one overrange event
  wire evt_overrange;
  // straps are meant to be static, so any move is worth telling software
  wire evt_strap;

  assign evt_overrange = valid_q & flag_q;
  assign evt_strap = strap_changed;
  assign evt_now = {evt_strap, evt_overrange};
  assign clear_mask = wr_clear ? AVS_WRITEDATA_I[`EVT_WIDTH-1:0] : '0;

  // an event is recorded even while its enable is off, and interrupts once enabled
  // a new event wins over a clear in the same cycle so none is lost
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clear_mask) | evt_now;
    end
  end

  // count flagged words; sticks at full scale rather than wrapping
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      ovr_count_q <= 16'h0000;
    end else if (evt_now[`EVT_OVERRANGE_BIT] && ovr_count_q != 16'hFFFF) begin
      ovr_count_q <= ovr_count_q + 16'h0001;
    end
  end

  // level interrupt from registers only, so it cannot glitch with bus traffic
  assign IRQ_O = |(status_q & enable_q);

  // ---------------- aperture delay ----------------

  // sign extended trim in picoseconds
  wire [15:0] trim_ext;
  // trimmed delay figure
  wire [15:0] trim_delay;

  assign trim_ext = {{8{trim_q[7]}}, trim_q};
  assign trim_delay = `APERTURE_NOMINAL_PS + trim_ext;

  // the figure is reported only; the analog delay line itself sits outside this block
  // nominal unless trim enabled
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      APERTURE_DELAY_O <= `APERTURE_NOMINAL_PS;
    end else begin
      APERTURE_DELAY_O <= trim_on ? trim_delay : `APERTURE_NOMINAL_PS;
    end
  end

endmodule

// file: rtl/adc_fmt_params.svh
// register offsets, field positions, reset values and fixed words of the output formatter
`ifndef ADC_FMT_PARAMS_SVH
`define ADC_FMT_PARAMS_SVH

// register byte offsets on the avalon slave
`define REG_STATUS_OFS 5'h00
`define REG_CLEAR_OFS 5'h04
`define REG_ENABLE_OFS 5'h08
`define REG_MODE_OFS 5'h0C
`define REG_TRIM_OFS 5'h10
`define REG_OVR_COUNT_OFS 5'h14

// event bit positions in status, clear and enable
`define EVT_OVERRANGE_BIT 0
`define EVT_STRAP_CHANGE_BIT 1
`define EVT_WIDTH 2

// mode register field positions (inverted synchronised strap levels, one when a mode is on)
`define MODE_GRAY_BIT 0
`define MODE_PATTERN_BIT 1
`define MODE_DECIMATE_BIT 2
`define MODE_TRIM_BIT 3

// reset values
`define ENABLE_RESET 2'h0
`define TRIM_RESET 8'h00
`define STRAP_RESET 4'hF

// checkerboard words, 0101010101 and 1010101010
`define PATTERN_EVEN 10'h155
`define PATTERN_ODD 10'h2AA

// nominal aperture delay in picoseconds
`define APERTURE_NOMINAL_PS 16'h00A0

// unmapped reads answer this
`define READ_DEFAULT 32'h0000_0000

`endif

// file: rtl/adc_fmt_pkg.sv
// types shared by the output formatter modules
package adc_fmt_pkg;

  // one output sample word
  typedef logic [9:0] word_type;

  // output coding of the sample word
  typedef enum logic {
    CODING_BINARY = 1'b0,
    CODING_GRAY = 1'b1
  } coding_type;

endpackage

// file: rtl/coder_link_if.sv
// carrier between the formatter top and its word coder
`timescale 1ns/1ps
interface coder_link_if;
  logic [9:0] raw_word; // quantizer result, straight binary
  logic over; // input above positive full scale
  logic under; // input below negative full scale
  adc_fmt_pkg::coding_type coding; // binary or gray
  logic pattern_on; // checkerboard replaces samples
  logic pattern_phase; // which checkerboard word this cycle
  logic [9:0] coded_word; // finished word
  logic coded_flag; // finished overrange flag

  // top drives the sample and modes, reads the result
  modport top (
    output raw_word, over, under, coding, pattern_on, pattern_phase,
    input coded_word, coded_flag
  );
  // coder reads the sample and modes, returns the result
  modport coder (
    input raw_word, over, under, coding, pattern_on, pattern_phase,
    output coded_word, coded_flag
  );
endinterface

// file: rtl/word_coder.sv
// combinational coding, saturation and checkerboard selection of one sample word
`timescale 1ns/1ps
`include "adc_fmt_params.svh"
module word_coder (
  coder_link_if.coder link
);
  // reflected binary of the raw result
  wire [9:0] gray_word;
  // word after the coding choice
  wire [9:0] plain_word;
  // word after saturation
  wire [9:0] sat_word;
  // checkerboard word for this cycle
  wire [9:0] pattern_word;

  assign gray_word = link.raw_word ^ {1'b0, link.raw_word[9:1]};

  assign plain_word = (link.coding == adc_fmt_pkg::CODING_GRAY) ? gray_word : link.raw_word;

  // saturation is applied after coding so a clipped word is all ones or all zeros
  // clip high ones
  assign sat_word = link.over ? 10'h3FF : (link.under ? 10'h000 : plain_word);

  assign pattern_word = link.pattern_phase ? `PATTERN_ODD : `PATTERN_EVEN;

  assign link.coded_word = link.pattern_on ? pattern_word : sat_word;

  assign link.coded_flag = link.pattern_on ? 1'b0 : (link.over | link.under);
endmodule

// file: verification/adc_fmt_properties.sv
// concurrent checks on the sample word stream of the formatter
`timescale 1ns/1ps
`include "adc_fmt_params.svh"
module adc_fmt_properties #(
  parameter int DECIMATION = 32
) (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic [9:0] QUANT_DATA_I,
  input wire logic QUANT_OVER_I,
  input wire logic QUANT_UNDER_I,
  input wire logic CODE_FORMAT_SELECT_I,
  input wire logic TEST_PATTERN_ENABLE_N_I,
  input wire logic DECIMATE_ENABLE_N_I,
  input wire logic DELAY_TRIM_ENABLE_N_I,
  input wire logic [9:0] DATA_O,
  input wire logic OVERRANGE_FLAG_O,
  input wire logic DATA_VALID_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [15:0] hist_q; // strap levels of the last four cycles
  logic [2:0] up_q; // cycles since reset, saturating
  logic [7:0] gap_q; // idle output cycles since the last word
  logic [6:0] dec_q; // cycles in decimation, saturating
  wire [3:0] straps = {CODE_FORMAT_SELECT_I, TEST_PATTERN_ENABLE_N_I,
                       DECIMATE_ENABLE_N_I, DELAY_TRIM_ENABLE_N_I};
  // straps steady long enough for the synchroniser to catch up
  wire steady = (hist_q == {4{straps}}) && (up_q == 3'h7);
  wire plain = steady && TEST_PATTERN_ENABLE_N_I && DECIMATE_ENABLE_N_I;
  wire in_range = !QUANT_OVER_I && !QUANT_UNDER_I;
  wire pattern_steady = steady && !TEST_PATTERN_ENABLE_N_I && DECIMATE_ENABLE_N_I;
  // history and counters; mode resets high, so up_q and dec_q restart with reset
  always_ff @(posedge CLOCK_I) begin
    hist_q <= {hist_q[11:0], straps};
    up_q <= SYS_RST_I ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
    gap_q <= DATA_VALID_O ? 8'h00 : gap_q + {7'h00, gap_q != 8'hFF};
    dec_q <= (SYS_RST_I || DECIMATE_ENABLE_N_I) ? 7'h00 : dec_q + {6'h00, dec_q != 7'h7F};
  end
  sequence s_over; plain && QUANT_OVER_I; endsequence
  sequence s_under; plain && QUANT_UNDER_I; endsequence
  sequence s_alt; (DATA_O == ~$past(DATA_O)) ##1 (DATA_O == ~$past(DATA_O)); endsequence
  a_over_all_ones: assert property (s_over
    |=> DATA_O == 10'h3FF && OVERRANGE_FLAG_O) else $error("high clip wrong");
  a_under_all_zeros: assert property (s_under
    |=> DATA_O == 10'h000 && OVERRANGE_FLAG_O) else $error("low clip wrong");
  a_flag_in_range: assert property (plain && in_range |=> !OVERRANGE_FLAG_O)
    else $error("flag set in range");
  a_binary_word: assert property (plain && in_range && CODE_FORMAT_SELECT_I
    |=> DATA_O == $past(QUANT_DATA_I)) else $error("binary word wrong");
  a_gray_word: assert property (plain && in_range && !CODE_FORMAT_SELECT_I
    |=> DATA_O == ($past(QUANT_DATA_I) ^ ($past(QUANT_DATA_I) >> 1)))
    else $error("gray word wrong");
  a_pattern_toggle: assert property (pattern_steady
    |-> (!OVERRANGE_FLAG_O && DATA_O inside {`PATTERN_EVEN, `PATTERN_ODD}) ##0 s_alt)
    else $error("pattern wrong");
  a_valid_every: assert property (steady && DECIMATE_ENABLE_N_I |-> DATA_VALID_O)
    else $error("word missing");
  a_decim_spacing: assert property (dec_q == 7'h7F
    |-> DATA_VALID_O == (gap_q == DECIMATION - 1)) else $error("decimation spacing wrong");
endmodule

// file: verification/sample_sink.sv
// receiving logic model that counts the words it keeps
`timescale 1ns/1ps
module sample_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic discard_i, // straps moving, words not trusted
  input wire logic valid_i,
  output int count_o // words kept
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 0;
    end else if (valid_i && !discard_i) begin
      count_o <= count_o + 1;
    end
  end
endmodule

// file: verification/tb_adc_output_word_formatter.sv
// self-checking bench for the output word formatter
`timescale 1ns/1ps
`include "adc_fmt_params.svh"
module tb_adc_output_word_formatter;
  localparam int DECIMATION = 32;
  logic CLOCK_I = 1'b0;
  logic SYS_RST_I = 1'b1;
  logic [9:0] QUANT_DATA_I = 10'h000;
  logic QUANT_OVER_I = 1'b0;
  logic QUANT_UNDER_I = 1'b0;
  logic [3:0] straps = 4'hF; // format, pattern_n, decimate_n, trim_n
  logic [4:0] AVS_ADDRESS_I = 5'h00;
  logic AVS_READ_I = 1'b0;
  logic AVS_WRITE_I = 1'b0;
  logic [31:0] AVS_WRITEDATA_I = 32'h0000_0000;
  logic [3:0] AVS_BYTEENABLE_I = 4'hF;
  logic [9:0] DATA_O, prev_q;
  logic OVERRANGE_FLAG_O, DATA_VALID_O, AVS_WAITREQUEST_O, IRQ_O;
  logic [15:0] APERTURE_DELAY_O;
  logic [31:0] AVS_READDATA_O, rd;
  logic [10:0] exp_q; // expected flag and word of the last sample
  logic [3:0] exp_mode; // expected mode register bits of the current straps
  logic chk_on = 1'b0, gray_m = 1'b0, pat_m = 1'b0, ovr_en = 1'b1, discard = 1'b1;
  int n_mismatch = 0, total_checks = 0, count, n0, r;
  int n_ovr = 0; // flagged words seen leaving the block
  logic [3:0] modes [5] = '{4'hF, 4'h6, 4'hB, 4'hD, 4'hF}; // strap sets, one per test
  adc_output_word_formatter #(.WIDTH(10), .DECIMATION(DECIMATION)) i_adc_output_word_formatter (
    .CLOCK_I, .SYS_RST_I, .QUANT_DATA_I, .QUANT_OVER_I, .QUANT_UNDER_I,
    .CODE_FORMAT_SELECT_I(straps[3]), .TEST_PATTERN_ENABLE_N_I(straps[2]),
    .DECIMATE_ENABLE_N_I(straps[1]), .DELAY_TRIM_ENABLE_N_I(straps[0]),
    .DATA_O, .OVERRANGE_FLAG_O, .DATA_VALID_O, .APERTURE_DELAY_O, .AVS_ADDRESS_I,
    .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I,
    .AVS_READDATA_O, .AVS_WAITREQUEST_O, .IRQ_O);
  sample_sink i_sample_sink (.clk_i(CLOCK_I), .rst_i(SYS_RST_I), .discard_i(discard),
    .valid_i(DATA_VALID_O), .count_o(count));
  always #25 CLOCK_I = ~CLOCK_I;
  // expected flag and word of one sample outside pattern mode
  function automatic logic [10:0] expect_word(logic [9:0] d, logic o, logic u, logic g);
    if (o) return {1'b1, 10'h3FF};
    if (u) return {1'b1, 10'h000};
    return {1'b0, g ? (d ^ (d >> 1)) : d};
  endfunction
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one avalon transfer; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rdata);
    int n;
    n = 0;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= wd;
    AVS_READ_I <= !wr;
    AVS_WRITE_I <= wr;
    do begin
      @(posedge CLOCK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 20);
    rdata = AVS_READDATA_O;
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
    if (AVS_WAITREQUEST_O !== 1'b0) begin
      n_mismatch++;
      end_of_test();
    end
    @(posedge CLOCK_I);
  endtask
  // random samples, clipping either way and full-scale codes as corner cases
  // the seed is given in the process that draws, so the stream is repeatable
  initial begin
    void'($urandom(32'hBD79FC02));
    forever begin
      @(posedge CLOCK_I);
      r = $urandom_range(15, 0);
      QUANT_DATA_I <= (r == 2) ? 10'h3FF : (r == 3) ? 10'h000 : 10'($urandom);
      QUANT_OVER_I <= ovr_en && (r == 0);
      QUANT_UNDER_I <= ovr_en && (r == 1);
    end
  end
  // each plain word against the sample of the cycle before, a pattern word against the inverted word before
  always @(posedge CLOCK_I) begin
    if (chk_on && pat_m) begin
      check({OVERRANGE_FLAG_O, DATA_O} === {1'b0, ~prev_q}, "pattern");
    end
    if (chk_on && !pat_m) begin
      check({OVERRANGE_FLAG_O, DATA_O} === exp_q, "word");
    end
    if (DATA_VALID_O && OVERRANGE_FLAG_O) n_ovr++;
    exp_q <= expect_word(QUANT_DATA_I, QUANT_OVER_I, QUANT_UNDER_I, gray_m);
    prev_q <= DATA_O;
  end
  initial begin
    repeat (10) @(posedge CLOCK_I);
    SYS_RST_I <= 1'b0;
    repeat (2) @(posedge CLOCK_I);
    bus(1'b0, `REG_ENABLE_OFS, 32'h0000_0000, rd);
    check(rd === 32'h0000_0000, "enable reset");
    bus(1'b1, `REG_TRIM_OFS, 32'h0000_00F6, rd); // trim of minus ten
    for (int k = 0; k < 5; k++) begin
      discard <= 1'b1;
      straps <= modes[k];
      gray_m <= !modes[k][3];
      pat_m <= !modes[k][2];
      repeat (8) @(posedge CLOCK_I);
      chk_on <= modes[k][1];
      discard <= 1'b0;
      @(posedge CLOCK_I);
      n0 = count;
      repeat (320) @(posedge CLOCK_I);
      check(count - n0 == (modes[k][1] ? 320 : 320 / DECIMATION), "rate");
      check(APERTURE_DELAY_O === (modes[k][0] ? 16'h00A0 : 16'h0096), "aperture");
      bus(1'b0, `REG_MODE_OFS, 32'h0000_0000, rd);
      exp_mode = ~{modes[k][0], modes[k][1], modes[k][2], modes[k][3]};
      check(rd === {28'h0, exp_mode}, "mode");
      chk_on <= 1'b0;
      $display("test %0d done", k);
    end
    ovr_en <= 1'b0;
    repeat (4) @(posedge CLOCK_I);
    bus(1'b0, `REG_STATUS_OFS, 32'h0000_0000, rd);
    check(rd[0] === 1'b1 && IRQ_O === 1'b0, "overrange event");
    bus(1'b0, `REG_OVR_COUNT_OFS, 32'h0000_0000, rd);
    check(rd === 32'(n_ovr), "overrange count");
    bus(1'b1, `REG_ENABLE_OFS, 32'h0000_0001, rd);
    check(IRQ_O === 1'b1, "irq raised");
    bus(1'b1, `REG_ENABLE_OFS, 32'h0000_0000, rd);
    check(IRQ_O === 1'b0, "irq masked");
    bus(1'b1, `REG_CLEAR_OFS, 32'h0000_0003, rd);
    bus(1'b1, `REG_ENABLE_OFS, 32'h0000_0001, rd);
    bus(1'b0, `REG_STATUS_OFS, 32'h0000_0000, rd);
    check(rd === 32'h0000_0000 && IRQ_O === 1'b0, "irq cleared");
    AVS_BYTEENABLE_I <= 4'hE;
    bus(1'b1, `REG_ENABLE_OFS, 32'h0000_0000, rd);
    AVS_BYTEENABLE_I <= 4'hF;
    bus(1'b0, `REG_ENABLE_OFS, 32'h0000_0000, rd);
    check(rd === 32'h0000_0001, "write without lane 0");
    bus(1'b0, 5'h1C, 32'h0000_0000, rd);
    check(rd === 32'h0000_0000, "unmapped read");
    bus(1'b1, `REG_MODE_OFS, 32'h0000_000F, rd);
    bus(1'b0, `REG_MODE_OFS, 32'h0000_0000, rd);
    check(rd === 32'h0000_0000, "mode read-only");
    $display("test 5 done");
    end_of_test();
  end
endmodule
bind adc_output_word_formatter adc_fmt_properties #(.DECIMATION(DECIMATION)) i_adc_fmt_properties (
  .CLOCK_I, .SYS_RST_I, .QUANT_DATA_I, .QUANT_OVER_I, .QUANT_UNDER_I, .CODE_FORMAT_SELECT_I,
  .TEST_PATTERN_ENABLE_N_I, .DECIMATE_ENABLE_N_I, .DELAY_TRIM_ENABLE_N_I, .DATA_O,
  .OVERRANGE_FLAG_O, .DATA_VALID_O);
